// ==== include/second_pipe_pkg.sv ====
`default_nettype none
package second_pipe_pkg;

   // ======================================================================
   // register map
   localparam int          ADDR_W          = 20;
   localparam logic [19:0] OFS_HORIZ_TOTAL = 20'h61000;
   localparam logic [19:0] OFS_HORIZ_BLANK = 20'h61004;
   localparam logic [19:0] OFS_HORIZ_SYNC  = 20'h61008;
   localparam logic [19:0] OFS_VERT_TOTAL  = 20'h6100C;
   localparam logic [19:0] OFS_VERT_BLANK  = 20'h61010;
   localparam logic [19:0] OFS_VERT_SYNC   = 20'h61014;
   localparam logic [19:0] OFS_SRC_SIZE    = 20'h6101C;
   localparam logic [19:0] OFS_BORDER      = 20'h61020;
   localparam logic [19:0] OFS_VSYNC_SHIFT = 20'h61028;
   localparam logic [19:0] OFS_DATA_M1     = 20'h61030;
   localparam logic [19:0] OFS_DATA_N1     = 20'h61034;
   localparam logic [19:0] OFS_LINK_M1     = 20'h61040;
   localparam logic [19:0] OFS_LINK_N1     = 20'h61044;
   localparam logic [19:0] OFS_LINK_M2     = 20'h61048;
   localparam logic [19:0] OFS_LINK_N2     = 20'h6104C;

   // ======================================================================
   // reset values and writable bit masks
   localparam logic [31:0] RST_ZERO        = 32'h00000000;
   localparam logic [31:0] RST_DATA_M1     = 32'h7E000000;
   localparam logic [31:0] MASK_TOTAL      = 32'h1FFF0FFF;
   localparam logic [31:0] MASK_WINDOW     = 32'h1FFF1FFF;
   localparam logic [31:0] MASK_SRC        = 32'h0FFF0FFF;
   localparam logic [31:0] MASK_COLOR      = 32'h00FFFFFF;
   localparam logic [31:0] MASK_SHIFT      = 32'h00001FFF;
   localparam logic [31:0] MASK_DATA_M     = 32'h7EFFFFFF;
   localparam logic [31:0] MASK_RATIO      = 32'h00FFFFFF;

   // ======================================================================
   // field layout
   localparam int TIME_W   = 13;
   localparam int SRC_W    = 12;
   localparam int COLOR_W  = 24;
   localparam int RATIO_W  = 24;
   localparam int TU_W     = 6;
   localparam int UPPER_LSB = 16;
   localparam int TU_LSB   = 25;

   // upper field of a timing register: total or end, minus one
   function automatic logic [12:0] upperField(input logic [31:0] r);
      upperField = r[28:16];
   endfunction

   // lower field: active or start, minus one
   function automatic logic [12:0] lowerField(input logic [31:0] r);
      lowerField = r[12:0];
   endfunction

   // both bounds are stored minus one, so a count strictly above the start
   // field and not above the end field lies inside the real window
   function automatic logic inWindow(input logic [12:0] count,
                                     input logic [12:0] startF,
                                     input logic [12:0] endF);
      inWindow = (count > startF) && (count <= endF);
   endfunction

endpackage
`default_nettype wire

// ==== include/raster_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface raster_if;
   logic [12:0] hTotalField;
   logic [12:0] vTotalField;
   logic        interlaced;
   logic [12:0] hCount;
   logic [12:0] vCount;
   logic        secondField;

   modport counter (
      input  hTotalField,
      input  vTotalField,
      input  interlaced,
      output hCount,
      output vCount,
      output secondField
   );

   modport pipe (
      output hTotalField,
      output vTotalField,
      output interlaced,
      input  hCount,
      input  vCount,
      input  secondField
   );
endinterface
`default_nettype wire

// ==== rtl/raster_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
module raster_counter (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic ce,
   raster_if.counter raster
);

   typedef struct packed {
      logic [12:0] hCount;
      logic [12:0] vCount;
      logic        secondField;
   } count_t;

   count_t cur;
   count_t next_cur;

   // ======================================================================
   // pixel and line counters
   always_comb begin
      next_cur = cur;
      if (ce) begin
         if (cur.hCount >= raster.hTotalField) begin
            next_cur.hCount = 13'h0000;
            if (cur.vCount >= raster.vTotalField) begin
               next_cur.vCount      = 13'h0000;
               // progressive modes never enter the second field
               next_cur.secondField = raster.interlaced ? ~cur.secondField : 1'b0;
            end else begin
               next_cur.vCount = cur.vCount + 13'h0001;
            end
         end else begin
            next_cur.hCount = cur.hCount + 13'h0001;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign raster.hCount      = cur.hCount;
   assign raster.vCount      = cur.vCount;
   assign raster.secondField = cur.secondField;

endmodule
`default_nettype wire

// ==== rtl/second_pipe_timing_generator.sv ====
`timescale 1ns/1ps
`default_nettype none
module second_pipe_timing_generator (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   input  wire logic [19:0] regAddr,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   input  wire logic [31:0] regWriteData,
   output logic      [31:0] regReadData,
   input  wire logic        interlaceMode,
   input  wire logic        interlaceShiftMode,
   input  wire logic        vgaMode,
   input  wire logic [23:0] vgaOverscanColor,
   input  wire logic        pseudoBorder,
   input  wire logic        lowPowerRefresh,
   input  wire logic [23:0] pixelIn,
   output logic      [23:0] pixelOut,
   output logic             hBlank,
   output logic             vBlank,
   output logic             hSync,
   output logic             vSync,
   output logic             activeVideo,
   output logic             borderVideo,
   output logic             secondField,
   output logic      [11:0] sourceWidth,
   output logic      [11:0] sourceHeight,
   output logic      [5:0]  transferUnitLength,
   output logic      [23:0] dataRatioM,
   output logic      [23:0] dataRatioN,
   output logic      [23:0] linkRatioM,
   output logic      [23:0] linkRatioN,
   output logic             secondaryRatioSet
);

   typedef struct packed {
      logic [31:0] horizTotalActive;
      logic [31:0] horizBlankWindow;
      logic [31:0] horizSyncWindow;
      logic [31:0] vertTotalActive;
      logic [31:0] vertBlankWindow;
      logic [31:0] vertSyncWindow;
      logic [31:0] sourceImageSize;
      logic [31:0] borderFillColor;
      logic [31:0] secondFieldVsyncOffset;
      logic [31:0] dataRatioMPending;
      logic [31:0] dataRatioMLive;
      logic [31:0] dataRatioNFirst;
      logic [31:0] linkRatioMFirst;
      logic [31:0] linkRatioNFirst;
      logic [31:0] linkRatioMSecond;
      logic [31:0] linkRatioNSecond;
      logic        ratioArmed;
      logic        hBlankOut;
      logic        vBlankOut;
      logic        hSyncOut;
      logic        vSyncOut;
      logic        activeOut;
      logic        borderOut;
      logic        fieldOut;
      logic        lowPowerOut;
      logic [23:0] pixel;
      logic [31:0] readData;
   } state_t;

   state_t cur;
   state_t next_cur;

   raster_if raster ();

   raster_counter counter (
      .clk    (clk),
      .nrst   (nrst),
      .ce     (ce),
      .raster (raster)
   );

   // ======================================================================
   // raster geometry handed to the counters
   assign raster.hTotalField = second_pipe_pkg::upperField(cur.horizTotalActive);
   assign raster.vTotalField = second_pipe_pkg::upperField(cur.vertTotalActive);
   assign raster.interlaced  = interlaceMode;

   // ======================================================================
   // window decode on the current counts
   logic [12:0] hActiveField;
   logic [12:0] vActiveField;
   logic        hInActive;
   logic        vInActive;
   logic        hInBlank;
   logic        vInBlank;
   logic        hInSync;
   logic        vInSync;
   logic [13:0] hTotalReal;
   logic [13:0] hSyncStartReal;
   logic [12:0] vsyncEdge;
   logic        atVsyncEdge;
   logic        blankRising;

   always_comb begin
      hActiveField = {1'b0, cur.horizTotalActive[11:0]};
      vActiveField = {1'b0, cur.vertTotalActive[11:0]};
      hInActive    = raster.hCount <= hActiveField;
      vInActive    = raster.vCount <= vActiveField;
      hInBlank     = second_pipe_pkg::inWindow(raster.hCount,
                        second_pipe_pkg::lowerField(cur.horizBlankWindow),
                        second_pipe_pkg::upperField(cur.horizBlankWindow));
      vInBlank     = second_pipe_pkg::inWindow(raster.vCount,
                        second_pipe_pkg::lowerField(cur.vertBlankWindow),
                        second_pipe_pkg::upperField(cur.vertBlankWindow));
      hInSync      = second_pipe_pkg::inWindow(raster.hCount,
                        second_pipe_pkg::lowerField(cur.horizSyncWindow),
                        second_pipe_pkg::upperField(cur.horizSyncWindow));
      vInSync      = second_pipe_pkg::inWindow(raster.vCount,
                        second_pipe_pkg::lowerField(cur.vertSyncWindow),
                        second_pipe_pkg::upperField(cur.vertSyncWindow));
      // shift math is done on real values, one above the stored fields
      hTotalReal     = {1'b0, raster.hTotalField} + 14'h0001;
      hSyncStartReal = {1'b0, second_pipe_pkg::lowerField(cur.horizSyncWindow)}
                       + 14'h0001;
      if (interlaceMode && raster.secondField) begin
         if (interlaceShiftMode) begin
            vsyncEdge = cur.secondFieldVsyncOffset[12:0];
         end else begin
            vsyncEdge = hTotalReal[13:1];
         end
      end else begin
         // a real start above the real line total wraps to pixel zero
         vsyncEdge = (hSyncStartReal > hTotalReal) ? 13'h0000 : hSyncStartReal[12:0];
      end
      atVsyncEdge = raster.hCount == vsyncEdge;
      blankRising = vInBlank && !cur.vBlankOut;
   end

   // ======================================================================
   // register write decode
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [31:0] mask);
      merge = (old & ~mask) | (data & mask);
   endfunction

   logic writeLinkN1;

   always_comb begin
      next_cur    = cur;
      writeLinkN1 = 1'b0;
      if (ce) begin
         if (regWrite) begin
            if (regAddr == second_pipe_pkg::OFS_HORIZ_TOTAL) begin
               next_cur.horizTotalActive = regWriteData & second_pipe_pkg::MASK_TOTAL;
            end else if (regAddr == second_pipe_pkg::OFS_HORIZ_BLANK) begin
               next_cur.horizBlankWindow = regWriteData & second_pipe_pkg::MASK_WINDOW;
            end else if (regAddr == second_pipe_pkg::OFS_HORIZ_SYNC) begin
               next_cur.horizSyncWindow = regWriteData & second_pipe_pkg::MASK_WINDOW;
            end else if (regAddr == second_pipe_pkg::OFS_VERT_TOTAL) begin
               next_cur.vertTotalActive = regWriteData & second_pipe_pkg::MASK_TOTAL;
            end else if (regAddr == second_pipe_pkg::OFS_VERT_BLANK) begin
               next_cur.vertBlankWindow = regWriteData & second_pipe_pkg::MASK_WINDOW;
            end else if (regAddr == second_pipe_pkg::OFS_VERT_SYNC) begin
               next_cur.vertSyncWindow = regWriteData & second_pipe_pkg::MASK_WINDOW;
            end else if (regAddr == second_pipe_pkg::OFS_SRC_SIZE) begin
               next_cur.sourceImageSize = regWriteData & second_pipe_pkg::MASK_SRC;
            end else if (regAddr == second_pipe_pkg::OFS_BORDER) begin
               next_cur.borderFillColor = regWriteData & second_pipe_pkg::MASK_COLOR;
            end else if (regAddr == second_pipe_pkg::OFS_VSYNC_SHIFT) begin
               next_cur.secondFieldVsyncOffset = regWriteData & second_pipe_pkg::MASK_SHIFT;
            end else if (regAddr == second_pipe_pkg::OFS_DATA_M1) begin
               next_cur.dataRatioMPending = regWriteData & second_pipe_pkg::MASK_DATA_M;
            end else if (regAddr == second_pipe_pkg::OFS_DATA_N1) begin
               next_cur.dataRatioNFirst = regWriteData & second_pipe_pkg::MASK_RATIO;
            end else if (regAddr == second_pipe_pkg::OFS_LINK_M1) begin
               next_cur.linkRatioMFirst = regWriteData & second_pipe_pkg::MASK_RATIO;
            end else if (regAddr == second_pipe_pkg::OFS_LINK_N1) begin
               next_cur.linkRatioNFirst = regWriteData & second_pipe_pkg::MASK_RATIO;
               writeLinkN1 = 1'b1;
            end else if (regAddr == second_pipe_pkg::OFS_LINK_M2) begin
               next_cur.linkRatioMSecond = regWriteData & second_pipe_pkg::MASK_RATIO;
            end else if (regAddr == second_pipe_pkg::OFS_LINK_N2) begin
               next_cur.linkRatioNSecond = regWriteData & second_pipe_pkg::MASK_RATIO;
            end
         end

         // ===================================================================
         // register read decode; unmapped offsets read zero
         if (regRead) begin
            if (regAddr == second_pipe_pkg::OFS_HORIZ_TOTAL) begin
               next_cur.readData = cur.horizTotalActive;
            end else if (regAddr == second_pipe_pkg::OFS_HORIZ_BLANK) begin
               next_cur.readData = cur.horizBlankWindow;
            end else if (regAddr == second_pipe_pkg::OFS_HORIZ_SYNC) begin
               next_cur.readData = cur.horizSyncWindow;
            end else if (regAddr == second_pipe_pkg::OFS_VERT_TOTAL) begin
               next_cur.readData = cur.vertTotalActive;
            end else if (regAddr == second_pipe_pkg::OFS_VERT_BLANK) begin
               next_cur.readData = cur.vertBlankWindow;
            end else if (regAddr == second_pipe_pkg::OFS_VERT_SYNC) begin
               next_cur.readData = cur.vertSyncWindow;
            end else if (regAddr == second_pipe_pkg::OFS_SRC_SIZE) begin
               next_cur.readData = cur.sourceImageSize;
            end else if (regAddr == second_pipe_pkg::OFS_BORDER) begin
               next_cur.readData = cur.borderFillColor;
            end else if (regAddr == second_pipe_pkg::OFS_VSYNC_SHIFT) begin
               next_cur.readData = cur.secondFieldVsyncOffset;
            end else if (regAddr == second_pipe_pkg::OFS_DATA_M1) begin
               // software sees what it wrote, not the value in use
               next_cur.readData = cur.dataRatioMPending;
            end else if (regAddr == second_pipe_pkg::OFS_DATA_N1) begin
               next_cur.readData = cur.dataRatioNFirst;
            end else if (regAddr == second_pipe_pkg::OFS_LINK_M1) begin
               next_cur.readData = cur.linkRatioMFirst;
            end else if (regAddr == second_pipe_pkg::OFS_LINK_N1) begin
               next_cur.readData = cur.linkRatioNFirst;
            end else if (regAddr == second_pipe_pkg::OFS_LINK_M2) begin
               next_cur.readData = cur.linkRatioMSecond;
            end else if (regAddr == second_pipe_pkg::OFS_LINK_N2) begin
               next_cur.readData = cur.linkRatioNSecond;
            end else begin
               next_cur.readData = second_pipe_pkg::RST_ZERO;
            end
         end

         // ===================================================================
         // double-buffered data M; an arming write in the update cycle stays armed
         if (cur.ratioArmed && blankRising) begin
            next_cur.dataRatioMLive = cur.dataRatioMPending;
         end
         next_cur.ratioArmed = (cur.ratioArmed && !blankRising) || writeLinkN1;
         next_cur.lowPowerOut = lowPowerRefresh;

         // ===================================================================
         // blank, sync and pixel outputs
         next_cur.hBlankOut = hInBlank;
         next_cur.vBlankOut = vInBlank;
         next_cur.hSyncOut  = hInSync;
         if (atVsyncEdge) begin
            next_cur.vSyncOut = vInSync;
         end
         next_cur.activeOut = hInActive && vInActive && !pseudoBorder;
         next_cur.borderOut = (!(hInActive && vInActive) && !(hInBlank || vInBlank))
                              || pseudoBorder;
         next_cur.fieldOut  = raster.secondField;
         if (hInBlank || vInBlank) begin
            next_cur.pixel = 24'h000000;
         end else if (next_cur.borderOut) begin
            // legacy VGA keeps its own overscan colour
            next_cur.pixel = vgaMode ? vgaOverscanColor
                                     : cur.borderFillColor[23:0];
         end else begin
            next_cur.pixel = pixelIn;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cur                   <= '0;
         cur.dataRatioMPending <= second_pipe_pkg::RST_DATA_M1;
         cur.dataRatioMLive    <= second_pipe_pkg::RST_DATA_M1;
      end else begin
         cur <= next_cur;
      end
   end

   // ======================================================================
   // outputs, all from flops
   assign regReadData        = cur.readData;
   assign pixelOut           = cur.pixel;
   assign hBlank             = cur.hBlankOut;
   assign vBlank             = cur.vBlankOut;
   assign hSync              = cur.hSyncOut;
   assign vSync              = cur.vSyncOut;
   assign activeVideo        = cur.activeOut;
   assign borderVideo        = cur.borderOut;
   assign secondField        = cur.fieldOut;
   assign sourceWidth        = cur.sourceImageSize[27:16];
   assign sourceHeight       = cur.sourceImageSize[11:0];
   assign transferUnitLength = cur.dataRatioMLive[30:25];
   assign dataRatioM         = cur.dataRatioMLive[23:0];
   assign dataRatioN         = cur.dataRatioNFirst[23:0];
   // the secondary set carries link values only, data stays on the primary set
   assign linkRatioM         = cur.lowPowerOut ? cur.linkRatioMSecond[23:0]
                                               : cur.linkRatioMFirst[23:0];
   assign linkRatioN         = cur.lowPowerOut ? cur.linkRatioNSecond[23:0]
                                               : cur.linkRatioNFirst[23:0];
   assign secondaryRatioSet  = cur.lowPowerOut;

endmodule
`default_nettype wire

// ==== testbench/second_pipe_timing_generator_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module second_pipe_timing_generator_asserts (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        ce,
   input wire logic [19:0] regAddr,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [31:0] regWriteData,
   input wire logic [31:0] regReadData,
   input wire logic        vgaMode,
   input wire logic [23:0] vgaOverscanColor,
   input wire logic        lowPowerRefresh,
   input wire logic [23:0] pixelIn,
   input wire logic [23:0] pixelOut,
   input wire logic        hBlank,
   input wire logic        vBlank,
   input wire logic        hSync,
   input wire logic        vSync,
   input wire logic        activeVideo,
   input wire logic        borderVideo,
   input wire logic        secondField,
   input wire logic [23:0] dataRatioM,
   input wire logic        secondaryRatioSet
);
   // ======================================================================
   // mirror of the border word, rebuilt from the write strobe
   logic [23:0] border;
   wire         inBorder = borderVideo && !hBlank && !vBlank;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) border <= 24'h000000;
      else if (ce && regWrite && regAddr == 20'h61020) border <= regWriteData[23:0];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // ======================================================================
   // checks
   a_border_color: assert property (
      inBorder && !$past(vgaMode) |-> pixelOut == $past(border))
      else $error("border colour wrong");
   a_vga_overscan: assert property (
      inBorder && $past(vgaMode) |-> pixelOut == $past(vgaOverscanColor))
      else $error("overscan colour wrong");
   a_blank_black: assert property (hBlank || vBlank |-> pixelOut == 24'h000000)
      else $error("pixel not black in blank");
   a_active_pass: assert property (
      activeVideo |-> pixelOut == $past(pixelIn) && !borderVideo)
      else $error("active pixel not passed");
   a_vsync_align: assert property ($rose(vSync) && !secondField |-> $rose(hSync))
      else $error("vsync not on hsync start");
   a_ratio_report: assert property (
      $past(nrst) |-> secondaryRatioSet == $past(lowPowerRefresh))
      else $error("ratio set flag wrong");
   a_datam_update: assert property ($changed(dataRatioM) |-> $rose(vBlank))
      else $error("data M changed outside vblank start");
   a_border_read: assert property (
      regRead && ce && regAddr == 20'h61020 |=> regReadData == {8'h00, $past(border)})
      else $error("border read wrong");
   // ratio update lands, second field vsync seen, overscan used
   c_second_vsync: cover property ($rose(vSync) && secondField);
   c_datam_swap: cover property ($changed(dataRatioM));
   c_vga_border: cover property (inBorder && $past(vgaMode));
endmodule
bind second_pipe_timing_generator second_pipe_timing_generator_asserts chk (.*);
`default_nettype wire

// ==== testbench/dp_sink_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// stream encoder stand-in: counts fields and latches the ratio set once per field
module dp_sink_model (
   input  wire logic       clk,
   input  wire logic       vSync,
   input  wire logic       secondaryRatioSet,
   output logic      [7:0] frames = 8'h00,
   output logic            msaSet = 1'b0
);
   logic last = 1'b0;
   always @(posedge clk) begin
      last <= vSync;
      if (vSync && !last) begin
         frames <= frames + 8'h01;
         msaSet <= secondaryRatioSet;
      end
   end
endmodule
`default_nettype wire

// ==== testbench/second_pipe_timing_generator_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module second_pipe_timing_generator_tb_top;
   logic clk, nrst, ce, regWrite, regRead, interlaceMode, interlaceShiftMode, vgaMode, msaSet;
   logic pseudoBorder, lowPowerRefresh, hBlank, vBlank, hSync, vSync, activeVideo;
   logic borderVideo, secondField, secondaryRatioSet;
   logic [19:0] regAddr;
   logic [31:0] regWriteData, regReadData;
   logic [23:0] vgaOverscanColor, pixelIn, pixelOut, dataRatioM, dataRatioN;
   logic [23:0] linkRatioM, linkRatioN;
   logic [11:0] sourceWidth, sourceHeight;
   logic [5:0]  transferUnitLength;
   logic [7:0]  frames;
   int          mismatches = 0, tests_run = 0, cycles = 0;
   second_pipe_timing_generator dut (.*);
   dp_sink_model sink (.*);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // the run needs about 2000 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 10000) begin
         mismatches++;
         test_done();
      end
   end
   task automatic test_done();
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [19:0] a, input logic [31:0] d);
      @(posedge clk) #1 regAddr = a;
      regWriteData = d;
      regWrite = 1'b1;
      @(posedge clk) #1 regWrite = 1'b0;
   endtask
   task automatic rdc(input logic [19:0] a, input logic [31:0] exp);
      @(posedge clk) #1 regAddr = a;
      regRead = 1'b1;
      @(posedge clk) #1 regRead = 1'b0;
      chk(regReadData, exp);
   endtask
   // cycles from the last hsync rise to the second field vsync rise
   task automatic t_field(input logic mode, input int exp);
      int n = 0;
      logic h0, v0 = 1'b1;
      interlaceShiftMode = mode;
      wait (secondField === 1'b0);
      wait (secondField === 1'b1);
      while (!(vSync === 1'b1 && v0 === 1'b0)) begin
         {h0, v0} = {hSync, vSync};
         @(posedge clk) #1 n = (hSync && !h0) ? 0 : n + 1;
      end
      chk(n, exp);
   endtask
   task automatic t_raster();
      logic [19:0] ofs [7] = '{20'h61000, 20'h61004, 20'h61008, 20'h6100C, 20'h61010,
                               20'h61014, 20'h61028};
      logic [31:0] val [7] = '{32'h0013000B, 32'h0013000D, 32'h0011000F, 32'h00090005,
                               32'h00090006, 32'h00080007, 32'h00000006};
      logic [7:0]  f0;
      for (int i = 0; i < 7; i++) wr(ofs[i], val[i]);
      f0 = frames;
      repeat (200) @(posedge clk);
      chk(frames - f0, 32'h00000001);
      #1 interlaceMode = 1'b1;
      t_field(1'b0, 14);
      t_field(1'b1, 10);
      pseudoBorder = 1'b1;
      repeat (300) @(posedge clk);
      #1;
      while (hBlank || vBlank) @(posedge clk) #1;
      chk(pixelOut, 32'h00AABBCC);
      chk({activeVideo, borderVideo}, 32'h00000001);
      vgaMode = 1'b1;
      repeat (300) @(posedge clk);
      #1;
      while (hBlank || vBlank) @(posedge clk) #1;
      chk(pixelOut, 32'h005A5A5A);
      {pseudoBorder, vgaMode} = 2'b00;
   endtask
   task automatic t_ratio();
      @(negedge vBlank) wr(20'h61030, 32'h7E123456);
      wr(20'h61044, 32'h00000010);
      wr(20'h61034, 32'hFF654321);
      chk(dataRatioN, 32'h00654321);
      chk(dataRatioM, 32'h00000000);
      @(posedge vBlank) @(posedge clk) #1 chk(dataRatioM, 32'h00123456);
      wr(20'h61040, 32'h00000111);
      wr(20'h61048, 32'h00000222);
      wr(20'h6104C, 32'h00000333);
      lowPowerRefresh = 1'b1;
      repeat (2) @(posedge clk) #1 chk(linkRatioM, 32'h00000222);
      chk(linkRatioN, 32'h00000333);
      @(posedge vSync) @(posedge clk) #1 chk(msaSet, 32'h00000001);
   endtask
   initial begin
      {ce, nrst, regWrite, regRead, interlaceMode, interlaceShiftMode} = 6'b100000;
      {vgaMode, pseudoBorder, lowPowerRefresh} = 3'b000;
      {regAddr, regWriteData, vgaOverscanColor, pixelIn} = {20'h0, 32'h0, 24'h5A5A5A, 24'hC3C3C3};
      repeat (5) @(posedge clk);
      #1 nrst = 1'b1;
      rdc(20'h61030, 32'h7E000000);
      chk(transferUnitLength, 32'h0000003F);
      wr(20'h61020, 32'hFFAABBCC);
      rdc(20'h61020, 32'h00AABBCC);
      wr(20'h6101C, 32'hFFFFFFFF);
      rdc(20'h6101C, 32'h0FFF0FFF);
      chk({sourceWidth, sourceHeight}, 32'h00FFFFFF);
      rdc(20'h61024, 32'h00000000);
      // a frozen block must ignore a write strobe
      ce = 1'b0;
      wr(20'h61020, 32'h00112233);
      ce = 1'b1;
      rdc(20'h61020, 32'h00AABBCC);
      t_raster();
      t_ratio();
      test_done();
   end
endmodule
`default_nettype wire
